/* File: pmm_pkg.sv */
`default_nettype none
package pmm_pkg;
	// Port slots: P0, P3, P4, P5, P7, P9
	localparam int NPORT = 6;
	localparam int PW = 16;
	localparam int ADDR_W = 12;
	localparam int P0 = 0;
	localparam int P3 = 1;
	localparam int P4 = 2;
	localparam int P5 = 3;
	localparam int P7 = 4;
	localparam int P9 = 5;
	typedef logic [NPORT-1:0][PW-1:0] pmm_vec_t;
	// Implemented pins per port
	localparam pmm_vec_t VALID = {16'he3c3, 16'h03ff, 16'h003f, 16'h0007, 16'h003f, 16'h007f};
	// Ports with edge select pairs (P0, P3, P9)
	localparam pmm_vec_t EDGE_MASK = {16'he3c3, 16'h0000, 16'h0000, 16'h0000, 16'h003f, 16'h007f};
	// Port 7 analog pins, port 9 clock pin
	localparam pmm_vec_t ANA_MASK = {16'h0000, 16'h03ff, 64'h0};
	localparam pmm_vec_t PCL_MASK = {16'h2000, 80'h0};
	localparam logic [PW-1:0] P7_LOW_MASK = 16'h00ff;
	// Register slots inside a port window
	localparam logic [2:0] R_OUT = 3'h0;
	localparam logic [2:0] R_DIR = 3'h1;
	localparam logic [2:0] R_PMC = 3'h2;
	localparam logic [2:0] R_PU = 3'h3;
	localparam logic [2:0] R_RISE = 3'h4;
	localparam logic [2:0] R_FALL = 3'h5;
	localparam logic [2:0] R_STAT = 3'h6;
	localparam logic [2:0] R_MASK = 3'h7;
	// Global window and its registers
	localparam logic [2:0] G_PORT = 3'h6;
	localparam logic [2:0] G_KRM = 3'h0;
	localparam logic [2:0] G_ADC = 3'h1;
	localparam logic [2:0] G_CLK = 3'h2;
	localparam logic [2:0] G_P7H = 3'h3;
	localparam int P7_HI_LSB = 8;
	localparam int P7_HI_W = 2;
	// Special pin positions and fields
	localparam int NMI_BIT = 2;
	localparam int ADC_EXT_TRIGGER_BIT = 3;
	localparam int DEBUG_RESET_N_BIT = 5;
	localparam int KEY_W = 8;
	localparam int KEY_P5_W = 6;
	localparam int ADC_EN = 0;
	localparam int ADC_RISE = 1;
	localparam int ADC_FALL = 2;
	localparam int CLK_BUS_EN = 0;
	localparam int CLK_PCL_SUB = 1;
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
		logic psel;
		logic penable;
	} pmm_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pmm_apb_rsp_t;
	typedef struct packed {
		pmm_vec_t o;
		pmm_vec_t oe;
		pmm_vec_t pu;
	} pmm_pad_t;
	typedef struct packed {
		pmm_vec_t dOut, dir, pmc, pu, rise, fall, stat, mask, pinR, pinPrev;
		logic [KEY_W-1:0] key_return_mode_reg;
		logic [2:0] adcMode;
		logic [1:0] clkCtl;
		logic [31:0] prdata;
		logic slvErr;
		logic nmiReq;
		logic adcTrig;
	} pmm_state_t;
endpackage
`default_nettype wire

/* File: pmm_port_mux.sv */
`default_nettype none
// How it works
// - Port 0: seven pins, per-bit direction
// - Each pin selects port or alternate function
// - Port 0 edges from rise/fall select pair
// - Pull-up option register per port, fixed at zero on port 7
// - Port 3: six pins, own edge pair
// - Port 4: serial receive, transmit, clock
// - Port 5: timer, key, debug pins
// - Port 7: ten pins, analog in control
// - Port 9: nine sparse pins, edge pair
// - Debug reset low, asynchronous to debug unit
// - Key inputs raise key events per mode
// - A/D trigger governed by converter mode reg
// - Bus clock pin drives system clock
// - Clock pin drives main or subclock
// - Serial clock pin is three-state both ways
// - NMI pin is port bit after reset
module pmm_port_mux
	import pmm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire pmm_apb_req_t apbReq,
	output pmm_apb_rsp_t apbRsp,
	input wire pmm_vec_t pinIn,
	output pmm_pad_t pad,
	input wire pmm_vec_t altOut,
	input wire pmm_vec_t altOe,
	output pmm_vec_t periphIn,
	input wire logic mainClk,
	input wire logic subClk,
	input wire logic sysClk,
	output logic busClkOut,
	output logic busClkOe,
	output logic dbgResetN,
	output logic nmiReq,
	output logic adcTrig,
	output logic irq
);
	localparam pmm_state_t RST_STATE = '{dir: VALID, default: '0};

	pmm_state_t s_r;
	pmm_state_t s_nxt;
	pmm_vec_t riseEv;
	pmm_vec_t fallEv;
	pmm_vec_t edgeEv;
	pmm_vec_t keyVec;
	pmm_vec_t altEff;
	pmm_vec_t altOeEff;
	logic [KEY_W-1:0] keyNow;
	logic [KEY_W-1:0] keyOld;
	logic [KEY_W-1:0] keyMode;
	logic [KEY_W-1:0] keyEv;
	logic [2:0] pIdx;
	logic [2:0] rIdx;
	logic addrOk;
	logic wrEn;
	logic pclkVal;
	logic clrSeen;

	// Writable bits of a port register
	function automatic logic [PW-1:0] wrMask(input logic [2:0] pi, input logic [2:0] ri);
		logic [PW-1:0] m;
		m = VALID[pi];
		if (ri == R_RISE || ri == R_FALL)
		begin
			m = m & EDGE_MASK[pi];
		end
		if (pi == 3'(P7) && ri == R_DIR)
		begin
			m = m & P7_LOW_MASK;
		end
		if (pi == 3'(P7) && ri == R_PU)
		begin
			m = '0;
		end
		return m;
	endfunction

	// Read value of a register
	function automatic logic [31:0] rdVal(input pmm_state_t st, input logic [2:0] pi, input logic [2:0] ri);
		logic [PW-1:0] v;
		v = '0;
		if (pi == G_PORT)
		begin
			unique case (ri)
				G_KRM: v = PW'(st.key_return_mode_reg);
				G_ADC: v = PW'(st.adcMode);
				G_CLK: v = PW'(st.clkCtl);
				G_P7H: v = PW'(st.dir[P7][P7_HI_LSB +: P7_HI_W]);
				default: v = '0;
			endcase
		end
		else
		begin
			unique case (ri)
				R_OUT: v = (st.dir[pi] & st.pinR[pi]) | (~st.dir[pi] & st.dOut[pi]);
				R_DIR: v = st.dir[pi];
				R_PMC: v = st.pmc[pi];
				R_PU: v = st.pu[pi];
				R_RISE: v = st.rise[pi];
				R_FALL: v = st.fall[pi];
				R_STAT: v = st.stat[pi];
				R_MASK: v = st.mask[pi];
			endcase
		end
		// Global registers keep their own widths
		return {16'h0000, (pi == G_PORT) ? v : (v & wrMask(pi, ri))};
	endfunction

	// Address decode
	assign pIdx = apbReq.paddr[7:5];
	assign rIdx = apbReq.paddr[4:2];
	assign addrOk = (apbReq.paddr[ADDR_W-1:8] == '0) && (apbReq.paddr[1:0] == 2'h0)
		&& ((pIdx < 3'(NPORT)) || (pIdx == G_PORT && rIdx <= G_P7H));
	assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite && addrOk;

	// Edge detection on registered pins
	assign riseEv = s_r.pinR & ~s_r.pinPrev;
	assign fallEv = ~s_r.pinR & s_r.pinPrev;
	assign edgeEv = s_r.pmc & EDGE_MASK & ((riseEv & s_r.rise) | (fallEv & s_r.fall));

	// Key lines: port 5 bits 0-5, port 9 bits 0-1
	assign keyNow = {s_r.pinR[P9][1:0], s_r.pinR[P5][KEY_P5_W-1:0]};
	assign keyOld = {s_r.pinPrev[P9][1:0], s_r.pinPrev[P5][KEY_P5_W-1:0]};
	assign keyMode = {s_r.dir[P9][1:0] & ~s_r.pmc[P9][1:0], s_r.dir[P5][KEY_P5_W-1:0] & ~s_r.pmc[P5][KEY_P5_W-1:0]};
	// falling key edge in input mode
	assign keyEv = s_r.key_return_mode_reg & keyMode & ~keyNow & keyOld;

	// Spread key events into status layout
	always_comb
	begin
		keyVec = '0;
		keyVec[P5][KEY_P5_W-1:0] = keyEv[KEY_P5_W-1:0];
		keyVec[P9][1:0] = keyEv[KEY_W-1:KEY_P5_W];
	end

	// Alternate drive: clock pin and analog pins
	// main or subclock timing output
	assign pclkVal = s_r.clkCtl[CLK_PCL_SUB] ? subClk : mainClk;
	assign altEff = (altOut & ~PCL_MASK) | ({NPORT{{PW{pclkVal}}}} & PCL_MASK);
	assign altOeEff = altOe & ~ANA_MASK;

	// Pad mux: port latch or alternate function
	// per-bit mode select
	assign pad.o = ((s_r.pmc & altEff) | (~s_r.pmc & s_r.dOut)) & VALID;
	assign pad.oe = ((s_r.pmc & altOeEff) | (~s_r.pmc & ~s_r.dir)) & VALID;
	assign pad.pu = s_r.pu & VALID & ~pad.oe;
	assign periphIn = s_r.pinR;

	assign busClkOut = s_r.clkCtl[CLK_BUS_EN] & sysClk;
	assign busClkOe = s_r.clkCtl[CLK_BUS_EN];
	assign dbgResetN = ~s_r.pmc[P0][DEBUG_RESET_N_BIT] | pinIn[P0][DEBUG_RESET_N_BIT];

	assign nmiReq = s_r.nmiReq;
	assign adcTrig = s_r.adcTrig;
	assign irq = |(s_r.stat & s_r.mask);
	assign apbRsp.prdata = s_r.prdata;
	assign apbRsp.pready = 1'b1;
	assign apbRsp.pslverr = apbReq.psel && apbReq.penable && s_r.slvErr;

	// Next-state of the whole block
	always_comb
	begin
		pmm_vec_t clr;
		logic [PW-1:0] m;
		logic [PW-1:0] wd;
		clr = '0;
		m = wrMask(pIdx, rIdx);
		wd = apbReq.pwdata[PW-1:0];
		s_nxt = s_r;
		s_nxt.pinPrev = s_r.pinR;
		s_nxt.pinR = pinIn & VALID;
		// interrupt only with an edge chosen
		s_nxt.nmiReq = edgeEv[P0][NMI_BIT];
		s_nxt.adcTrig = s_r.pmc[P0][ADC_EXT_TRIGGER_BIT] && s_r.adcMode[ADC_EN]
			&& ((riseEv[P0][ADC_EXT_TRIGGER_BIT] && s_r.adcMode[ADC_RISE])
			|| (fallEv[P0][ADC_EXT_TRIGGER_BIT] && s_r.adcMode[ADC_FALL]));
		// Read data staged in setup phase
		if (apbReq.psel && !apbReq.penable)
		begin
			s_nxt.slvErr = !addrOk;
			s_nxt.prdata = addrOk ? rdVal(s_r, pIdx, rIdx) : '0;
		end
		if (wrEn && pIdx == G_PORT)
		begin
			unique case (rIdx)
				G_KRM: s_nxt.key_return_mode_reg = apbReq.pwdata[KEY_W-1:0];
				G_ADC: s_nxt.adcMode = apbReq.pwdata[2:0];
				G_CLK: s_nxt.clkCtl = apbReq.pwdata[1:0];
				G_P7H: s_nxt.dir[P7][P7_HI_LSB +: P7_HI_W] = apbReq.pwdata[P7_HI_W-1:0];
				default: s_nxt.key_return_mode_reg = s_r.key_return_mode_reg;
			endcase
		end
		else if (wrEn)
		begin
			unique case (rIdx)
				R_OUT: s_nxt.dOut[pIdx] = (s_r.dOut[pIdx] & ~m) | (wd & m);
				R_DIR: s_nxt.dir[pIdx] = (s_r.dir[pIdx] & ~m) | (wd & m);
				R_PMC: s_nxt.pmc[pIdx] = wd & m;
				R_PU: s_nxt.pu[pIdx] = wd & m;
				R_RISE: s_nxt.rise[pIdx] = wd & m;
				R_FALL: s_nxt.fall[pIdx] = wd & m;
				R_STAT: clr[pIdx] = wd & m;
				R_MASK: s_nxt.mask[pIdx] = wd & m;
			endcase
		end
		// Sticky status, set beats clear
		s_nxt.stat = ((s_r.stat & ~clr) | edgeEv | keyVec) & VALID;
	end

	// State register
	// input port mode on reset
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_r <= RST_STATE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// Port 0 bit 0 status clear landing this cycle
	assign clrSeen = wrEn && pIdx == 3'(P0) && rIdx == R_STAT && apbReq.pwdata[0];

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_wrDir0;
		apbReq.psel && apbReq.penable && apbReq.pwrite && addrOk && pIdx == 3'(P0) && rIdx == R_DIR;
	endsequence
	sequence s_rise0;
		riseEv[P0][0] && s_r.rise[P0][0] && s_r.pmc[P0][0];
	endsequence
	sequence s_fall3;
		fallEv[P3][0] && s_r.fall[P3][0] && s_r.pmc[P3][0];
	endsequence
	sequence s_key0;
		s_r.key_return_mode_reg[0] && keyMode[0] && keyOld[0] && !keyNow[0];
	endsequence

	property p_resetState;
		$fell(rst) |-> s_r.dir == VALID && s_r.pu == '0 && s_r.pmc == '0 && pad.oe == '0;
	endproperty
	a_resetState: assert property (p_resetState) else $error("reset not input port mode");
	property p_dirWrite;
		s_wrDir0 |=> s_r.dir[P0] == ($past(apbReq.pwdata[PW-1:0]) & VALID[P0]);
	endproperty
	a_dirWrite: assert property (p_dirWrite) else $error("port0 direction write lost");
	property p_portMode;
		!s_r.pmc[P5][1] && !s_r.dir[P5][1] |-> pad.oe[P5][1] && pad.o[P5][1] == s_r.dOut[P5][1];
	endproperty
	a_portMode: assert property (p_portMode) else $error("port mode not driving latch");
	property p_rise0;
		s_rise0 |=> s_r.stat[P0][0] ##1 (s_r.stat[P0][0] || $past(clrSeen));
	endproperty
	a_rise0: assert property (p_rise0) else $error("port0 rise status lost");
	property p_fall3;
		s_fall3 |=> s_r.stat[P3][0];
	endproperty
	a_fall3: assert property (p_fall3) else $error("port3 fall edge missed");
	property p_rise0b;
		s_rise0 |=> s_r.stat[P0][0];
	endproperty
	a_rise0b: assert property (p_rise0b) else $error("port0 rise edge missed");
	property p_p9Gaps;
		pad.oe[P9][5:2] == '0 && pad.oe[P9][12:10] == '0;
	endproperty
	a_p9Gaps: assert property (p_p9Gaps) else $error("port9 gap pin driven");
	property p_key0;
		s_key0 |=> s_r.stat[P5][0] ##1 1'b1;
	endproperty
	a_key0: assert property (p_key0) else $error("key event missed");
	property p_adcTrig;
		s_r.pmc[P0][ADC_EXT_TRIGGER_BIT] && s_r.adcMode[ADC_EN] && s_r.adcMode[ADC_RISE] && riseEv[P0][ADC_EXT_TRIGGER_BIT] |=> adcTrig;
	endproperty
	a_adcTrig: assert property (p_adcTrig) else $error("adc trigger missed");
	property p_nmiQuiet;
		!s_r.rise[P0][NMI_BIT] && !s_r.fall[P0][NMI_BIT] |=> !nmiReq;
	endproperty
	a_nmiQuiet: assert property (p_nmiQuiet) else $error("nmi without edge select");
	property p_dbgRst;
		s_r.pmc[P0][DEBUG_RESET_N_BIT] && !pinIn[P0][DEBUG_RESET_N_BIT] |-> !dbgResetN;
	endproperty
	a_dbgRst: assert property (p_dbgRst) else $error("debug reset not passed");
	property p_analog;
		(pad.oe[P7] & s_r.pmc[P7]) == '0;
	endproperty
	a_analog: assert property (p_analog) else $error("analog pin driven");
	property p_irq;
		(s_rise0 and s_r.mask[P0][0]) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");
	sequence s_clr3;
		wrEn && pIdx == 3'(P3) && rIdx == R_STAT && apbReq.pwdata[0] && !edgeEv[P3][0];
	endsequence
	property p_clr3;
		s_clr3 |=> !s_r.stat[P3][0];
	endproperty
	a_clr3: assert property (p_clr3) else $error("port3 status not cleared");
	property p_pu7;
		s_r.pu[P7] == '0;
	endproperty
	a_pu7: assert property (p_pu7) else $error("analog port pull-up set");
	property p_pclkSub;
		s_r.pmc[P9][13] && s_r.clkCtl[CLK_PCL_SUB] |-> pad.o[P9][13] == subClk;
	endproperty
	a_pclkSub: assert property (p_pclkSub) else $error("clock pin not on subclock");
	property p_busOff;
		!s_r.clkCtl[CLK_BUS_EN] |-> !busClkOe && !busClkOut;
	endproperty
	a_busOff: assert property (p_busOff) else $error("bus clock pin active while off");
	property p_sckOe;
		s_r.pmc[P4][2] |-> pad.oe[P4][2] == altOe[P4][2];
	endproperty
	a_sckOe: assert property (p_sckOe) else $error("serial clock direction wrong");
	property p_dbgIdle;
		!s_r.pmc[P0][DEBUG_RESET_N_BIT] |-> dbgResetN;
	endproperty
	a_dbgIdle: assert property (p_dbgIdle) else $error("debug reset active in port mode");
	property p_resetOut;
		$fell(rst) |-> !nmiReq && !adcTrig && !irq;
	endproperty
	a_resetOut: assert property (p_resetOut) else $error("event output active after reset");
	property p_keyGate;
		!s_r.dir[P5][0] || s_r.pmc[P5][0] |-> !keyEv[0];
	endproperty
	a_keyGate: assert property (p_keyGate) else $error("key event outside input port mode");
endmodule // pmm_port_mux
`default_nettype wire

/* File: pmm_unused_guard.sv */
`default_nettype none
`default_nettype wire

/* File: pmm_board.sv */
`default_nettype none
module pmm_board
	import pmm_pkg::*;
(
	input wire logic core_clk,
	input wire pmm_pad_t pad,
	input wire pmm_vec_t drv,
	output pmm_vec_t pinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	// Device drive wins, otherwise the board level
	always_comb
	begin
		for (int p = 0; p < NPORT; p++)
			pinIn[p] = (pad.oe[p] & pad.o[p]) | (~pad.oe[p] & drv[p]);
	end
endmodule // pmm_board
`default_nettype wire

/* File: pmm_port_mux_tb_top.sv */
`default_nettype none
`define CHK(nm, e, a) begin totalChecks++; if ((a) !== (e)) begin nErrors++; $display("Error %s exp %h got %h", nm, e, a); end end
module pmm_port_mux_tb_top
	import pmm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst, mainClk, subClk, sysClk, busClkOut, busClkOe, dbgResetN, nmiReq, adcTrig, irq, err;
	pmm_apb_req_t apbReq;
	pmm_apb_rsp_t apbRsp;
	pmm_vec_t pinIn, altOut, altOe, drv, periph;
	pmm_pad_t pad;
	int nErrors, totalChecks, nmiCnt, adcCnt;
	logic [31:0] rd;
	logic [15:0] v, m, u;
	int sl[3] = '{P0, P3, P9};
	int bt[3] = '{4, 0, 14};
	pmm_port_mux pmm_port_mux_inst (.core_clk(core_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.pinIn(pinIn), .pad(pad), .altOut(altOut), .altOe(altOe), .periphIn(periph), .mainClk(mainClk),
		.subClk(subClk), .sysClk(sysClk), .busClkOut(busClkOut), .busClkOe(busClkOe),
		.dbgResetN(dbgResetN), .nmiReq(nmiReq), .adcTrig(adcTrig), .irq(irq));
	pmm_board pmm_board_inst (.core_clk(core_clk), .pad(pad), .drv(drv), .pinIn(pinIn));
	// Clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Random peripheral drives, clock sources, pulse counts
	always @(posedge core_clk)
	begin
		{mainClk, subClk, sysClk} <= 3'($urandom);
		altOut <= {$urandom, $urandom, $urandom};
		// Interrupt, trigger and reset pins are inputs in control mode
		altOe <= {$urandom, $urandom, $urandom} & ~EDGE_MASK;
		nmiCnt <= nmiCnt + int'(nmiReq === 1'b1);
		adcCnt <= adcCnt + int'(adcTrig === 1'b1);
	end
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input int s, input logic [2:0] r, input logic [31:0] d);
		@(posedge core_clk);
		apbReq <= '{{4'h0, 3'(s), r, 2'b00}, wr, d, 1'b1, 1'b0};
		@(posedge core_clk);
		apbReq.penable <= 1'b1;
		do
			@(posedge core_clk);
		while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic pin(input int p, b, input logic x);
		@(posedge core_clk);
		drv[p][b] <= x;
	endtask
	task automatic endSim();
		$display("checks %0d errors %0d", totalChecks, nErrors);
		if (nErrors == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge core_clk);
		nErrors++;
		endSim();
	end
	initial
	begin
		void'($urandom(32'h2e3a));
		rst = 1'b1;
		apbReq = '0;
		drv = '0;
		altOut = '0;
		altOe = '0;
		{mainClk, subClk, sysClk, nmiCnt, adcCnt, nErrors, totalChecks} = '0;
		drv[P0][DEBUG_RESET_N_BIT] = 1'b1;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		wt(1);
		`CHK("oe", '0, pad.oe)
		`CHK("pu", '0, pad.pu)
		`CHK("periph", pinIn & VALID, periph)
		for (int p = 0; p < NPORT; p++)
		begin
			m = (p == P7) ? P7_LOW_MASK : 16'hffff;
			apb(0, p, R_DIR, 0);
			`CHK("dir", VALID[p] & m, rd[15:0] & m)
			apb(0, p, R_PMC, 0);
			`CHK("pmc", 16'h0, rd[15:0])
		end
		$display("reset test done");
		// Per-bit direction, output latch, pull-up gating
		for (int p = 0; p < NPORT; p++)
		begin
			v = 16'($urandom);
			m = VALID[p] & ((p == P7) ? P7_LOW_MASK : 16'hffff);
			u = (p == P7) ? 16'h0 : VALID[p];
			apb(1, p, R_OUT, v);
			apb(1, p, R_PU, 32'hffff);
			apb(1, p, R_DIR, 0);
			wt(0);
			`CHK("oe", m, pad.oe[p])
			`CHK("out", v & m, pad.o[p] & m)
			`CHK("pu", u & ~m, pad.pu[p] & VALID[p])
			apb(0, p, R_OUT, 0);
			`CHK("rd", v & m, rd[15:0] & m)
			apb(1, p, R_DIR, 32'hffff);
			wt(0);
			`CHK("pu", u, pad.pu[p] & VALID[p])
			apb(1, p, R_PU, 0);
		end
		apb(1, G_PORT, G_P7H, 0);
		apb(1, P7, R_DIR, 0);
		wt(0);
		`CHK("oe7", 16'h03ff, pad.oe[P7])
		apb(1, P7, R_DIR, 32'hffff);
		apb(1, G_PORT, G_P7H, 3);
		$display("direction test done");
		// Alternate function takes the serial pins
		apb(1, P4, R_PMC, 7);
		repeat (4)
		begin
			wt(1);
			`CHK("altoe", altOe[P4][2:0], pad.oe[P4][2:0])
			`CHK("alto", altOut[P4][2:0] & altOe[P4][2:0], pad.o[P4][2:0] & altOe[P4][2:0])
		end
		apb(1, P4, R_PMC, 0);
		$display("alternate test done");
		// Edge select, mask, sticky status, write-one clear
		for (int i = 0; i < 3; i++)
		begin
			v = 16'h1 << bt[i];
			apb(1, sl[i], R_PMC, v);
			apb(1, sl[i], R_MASK, v);
			apb(1, sl[i], R_RISE, v);
			pin(sl[i], bt[i], 1);
			wt(4);
			`CHK("irq", 1'b1, irq)
			apb(1, sl[i], R_MASK, 0);
			wt(0);
			`CHK("irqm", 1'b0, irq)
			apb(1, sl[i], R_STAT, v);
			apb(1, sl[i], R_RISE, 0);
			apb(1, sl[i], R_FALL, v);
			pin(sl[i], bt[i], 0);
			wt(4);
			apb(0, sl[i], R_STAT, 0);
			`CHK("fall", v, rd[15:0])
			apb(1, sl[i], R_STAT, v);
			apb(1, sl[i], R_FALL, 0);
		end
		$display("edge test done");
		// NMI pin is a plain port bit until selected
		apb(1, P0, R_RISE, 4);
		pin(P0, NMI_BIT, 1);
		wt(5);
		`CHK("nmi0", 0, nmiCnt)
		apb(1, P0, R_PMC, 4);
		pin(P0, NMI_BIT, 0);
		pin(P0, NMI_BIT, 1);
		wt(5);
		`CHK("nmi1", 1, nmiCnt)
		// External trigger follows the converter mode bits
		apb(1, P0, R_PMC, 8);
		apb(1, G_PORT, G_ADC, 3);
		pin(P0, ADC_EXT_TRIGGER_BIT, 1);
		wt(5);
		`CHK("adc1", 1, adcCnt)
		apb(1, G_PORT, G_ADC, 0);
		pin(P0, ADC_EXT_TRIGGER_BIT, 0);
		pin(P0, ADC_EXT_TRIGGER_BIT, 1);
		wt(5);
		`CHK("adc0", 1, adcCnt)
		// Debug reset is active low in control mode
		apb(1, P0, R_PMC, 32);
		pin(P0, DEBUG_RESET_N_BIT, 0);
		wt(0);
		`CHK("debug_reset_n", 1'b0, dbgResetN)
		pin(P0, DEBUG_RESET_N_BIT, 1);
		$display("control pin test done");
		// Key event on falling edge in input port mode
		apb(1, G_PORT, G_KRM, 1);
		pin(P5, 0, 1);
		pin(P5, 0, 0);
		wt(4);
		apb(0, P5, R_STAT, 0);
		`CHK("key", 16'h1, rd[15:0])
		// Bus clock and programmable clock outputs
		apb(1, G_PORT, G_CLK, 1);
		apb(1, P9, R_PMC, 32'h2000);
		wt(1);
		`CHK("bclk", {1'b1, sysClk}, {busClkOe, busClkOut})
		`CHK("pcl", mainClk, pad.o[P9][13])
		apb(1, G_PORT, G_CLK, 2);
		wt(1);
		`CHK("pcls", subClk, pad.o[P9][13])
		// Unmapped slot is refused
		apb(0, 7, R_OUT, 0);
		`CHK("err", {1'b1, 32'h0}, {err, rd})
		$display("key clock test done");
		endSim();
	end
endmodule // pmm_port_mux_tb_top
`default_nettype wire
